// *** odtt_defines.svh ***
/*
 * register offsets, field positions, reset values and timing counts
 * for the on-die thermal throttle register bank.
 * assumes inclusion by bare name from the design file.
 */
`ifndef ODTT_DEFINES_SVH
`define ODTT_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets in configuration space
// ----------------------------------------------------------------
`define ODTT_OFS_STATUS 8'hf4
`define ODTT_OFS_COOL 8'hf6
`define ODTT_OFS_CTRL 8'hf7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ODTT_ST_CATASTROPHIC 0
`define ODTT_ST_THROTTLE 1
`define ODTT_ST_PEAK 2
`define ODTT_COOL_MAX 0
`define ODTT_CT_PEAK_DIS 0
`define ODTT_CT_HINT_EN 1
`define ODTT_CT_ALERT_CONN 2
`define ODTT_CT_NO_MGMT 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ODTT_RST_STATUS 8'h00
`define ODTT_RST_COOL 8'h00
`define ODTT_RST_CTRL 8'h00
`define ODTT_RST_PEAK 9'h100

// ----------------------------------------------------------------
// alert window timing
// ----------------------------------------------------------------
`define ODTT_WINDOW_US 1
`define ODTT_CLK_MHZ 125
`define ODTT_WINDOW_CYC (`ODTT_WINDOW_US * `ODTT_CLK_MHZ)

`endif

// *** odtt_pkg.sv ***
/*
 * types shared by the on-die thermal throttle register bank.
 * uses nothing from odtt_defines.svh.
 */
package odtt_pkg;
    typedef logic [8:0] odtt_temp_t;
    typedef logic [7:0] odtt_byte_t;
    typedef enum logic [1:0] {
        ODTT_SRC_NONE,
        ODTT_SRC_THROTTLE,
        ODTT_SRC_EXCURSION
    } odtt_alert_src_t;
endpackage : odtt_pkg

// *** odtt_sync.sv ***
/*
 * two flip-flop synchroniser for one level input.
 * assumes the input may change at any time relative to clk.
 */
`timescale 1ns/1ps
module odtt_sync (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // level in and out
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    always_ff @(posedge clk) begin
        if (reset) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : odtt_sync

// *** odtt_ctrl.sv ***
/*
 * status, cooling-level and control registers of the on-die thermal
 * throttling logic, with threshold compare, peak tracking, hint gating
 * and the windowed thermal alert pin.
 * assumes a byte-wide configuration access port on clk, thresholds
 * and sensor reading from same-clock logic, and an asynchronous
 * catastrophic trip input from the sensor pad.
 */
`timescale 1ns/1ps
`include "odtt_defines.svh"
module odtt_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire odtt_pkg::odtt_byte_t cfg_wdata,
    output odtt_pkg::odtt_byte_t cfg_rdata,
    output logic cfg_rvalid,
    // sensor and thresholds
    input wire odtt_pkg::odtt_temp_t live_sensor_reading,
    input wire odtt_pkg::odtt_temp_t high_threshold,
    input wire odtt_pkg::odtt_temp_t low_threshold,
    input wire odtt_pkg::odtt_temp_t standalone_throttle_threshold,
    input wire logic catastrophic_trip,
    // outputs to throttle logic and board
    output odtt_pkg::odtt_temp_t peak_temperature,
    output logic throttle_active,
    output logic throttle_hint,
    output logic thermal_alert_pin_n
);
    import odtt_pkg::*;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    odtt_byte_t throttle_status;
    odtt_byte_t die_cooling_level;
    odtt_byte_t throttle_control;
    logic trip_sync;
    logic throttle_prev;
    logic window_seen;
    logic [15:0] window_cnt;
    odtt_alert_src_t alert_src;

    odtt_sync u_trip_sync (
        .clk(clk),
        .reset(reset),
        .async_in(catastrophic_trip),
        .sync_out(trip_sync)
    );

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire sel_status = cfg_addr == `ODTT_OFS_STATUS;
    wire sel_cool = cfg_addr == `ODTT_OFS_COOL;
    wire sel_ctrl = cfg_addr == `ODTT_OFS_CTRL;
    wire wr_status = cfg_wr && sel_status;
    wire wr_cool = cfg_wr && sel_cool;
    wire wr_ctrl = cfg_wr && sel_ctrl;

    wire maximum_cooling = die_cooling_level[`ODTT_COOL_MAX];
    wire peak_tracking_disable = throttle_control[`ODTT_CT_PEAK_DIS];
    wire hint_enable = throttle_control[`ODTT_CT_HINT_EN];
    wire alert_connect = throttle_control[`ODTT_CT_ALERT_CONN];
    wire no_mgmt_controller_mode = throttle_control[`ODTT_CT_NO_MGMT];

    // ----------------------------------------------------------------
    // threshold compare and throttle selection
    // ----------------------------------------------------------------
    // signed compare; half-degree steps keep the same ordering
    wire above_high = $signed(live_sensor_reading) >=
        $signed(high_threshold);
    wire below_low = $signed(live_sensor_reading) <
        $signed(low_threshold);
    wire above_standalone = $signed(live_sensor_reading) >=
        $signed(standalone_throttle_threshold);
    wire excursion = above_high || below_low;
    wire throttle_cond = no_mgmt_controller_mode ? above_standalone
                                                 : above_high;
    wire next_throttle = throttle_cond && !maximum_cooling;
    // rising edge only, so a long episode sets the flag once
    wire throttle_rise = next_throttle && !throttle_prev;

    // ----------------------------------------------------------------
    // peak tracking
    // ----------------------------------------------------------------
    // tracking allowed unless disabled; maximum cooling forces it on
    wire track_en = !peak_tracking_disable || maximum_cooling;
    wire peak_grow = track_en &&
        ($signed(live_sensor_reading) > $signed(peak_temperature));
    // a disable write restarts tracking from the lowest value
    wire peak_restart = wr_ctrl && cfg_wdata[`ODTT_CT_PEAK_DIS];
    wire peak_set = peak_grow && !peak_tracking_disable;

    // ----------------------------------------------------------------
    // alert windows
    // ----------------------------------------------------------------
    wire window_end = window_cnt == 16'(`ODTT_WINDOW_CYC - 1);
    wire window_event = (alert_src == ODTT_SRC_THROTTLE) ? next_throttle :
                        (alert_src == ODTT_SRC_EXCURSION) ? excursion : 1'b0;

    always_comb begin
        alert_src = ODTT_SRC_NONE;
        if (alert_connect && !no_mgmt_controller_mode) begin
            alert_src = ODTT_SRC_THROTTLE;
        end else if (alert_connect) begin
            alert_src = ODTT_SRC_EXCURSION;
        end
    end

    // ----------------------------------------------------------------
    // status flags; set wins over a same-cycle clear
    // ----------------------------------------------------------------
    wire [2:0] st_set = {peak_set, throttle_rise, trip_sync};
    // only bits 2:0 exist; upper write bits are dropped
    wire [2:0] st_clr = wr_status ? cfg_wdata[2:0] : 3'h0;
    wire [2:0] next_st = st_set | (throttle_status[2:0] & ~st_clr);

    always_ff @(posedge clk) begin
        if (reset) begin
            throttle_status <= `ODTT_RST_STATUS;
        end else begin
            throttle_status <= {5'h00, next_st};
        end
    end

    // ----------------------------------------------------------------
    // control and cooling registers
    // ----------------------------------------------------------------
    // reserved bits are not stored, so they always read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            die_cooling_level <= `ODTT_RST_COOL;
            throttle_control <= `ODTT_RST_CTRL;
        end else begin
            if (wr_cool) begin
                die_cooling_level <= {7'h00, cfg_wdata[0]};
            end
            if (wr_ctrl) begin
                throttle_control <= {4'h0, cfg_wdata[3:0]};
            end
        end
    end

    // ----------------------------------------------------------------
    // peak register
    // ----------------------------------------------------------------
    // restart beats growth, so a disable write always lands on the floor
    always_ff @(posedge clk) begin
        if (reset) begin
            peak_temperature <= `ODTT_RST_PEAK;
        end else if (peak_restart) begin
            peak_temperature <= `ODTT_RST_PEAK;
        end else if (peak_grow) begin
            peak_temperature <= live_sensor_reading;
        end
    end

    // ----------------------------------------------------------------
    // throttle outputs
    // ----------------------------------------------------------------
    // hint and active change on one edge; no skew between them
    always_ff @(posedge clk) begin
        if (reset) begin
            throttle_prev <= 1'b0;
            throttle_active <= 1'b0;
            throttle_hint <= 1'b0;
        end else begin
            throttle_prev <= next_throttle;
            throttle_active <= next_throttle;
            throttle_hint <= next_throttle && hint_enable;
        end
    end

    // ----------------------------------------------------------------
    // alert pin
    // ----------------------------------------------------------------
    // events seen in one window drive the pin through the next one
    always_ff @(posedge clk) begin
        if (reset) begin
            window_cnt <= 16'h0000;
            window_seen <= 1'b0;
            thermal_alert_pin_n <= 1'b1;
        end else if (window_end) begin
            window_cnt <= 16'h0000;
            window_seen <= 1'b0;
            thermal_alert_pin_n <= !(window_seen || window_event);
        end else begin
            window_cnt <= window_cnt + 16'h0001;
            window_seen <= window_seen || window_event;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    wire [7:0] rd_mux = sel_status ? throttle_status :
                        sel_cool ? die_cooling_level :
                        sel_ctrl ? throttle_control : 8'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_rdata <= 8'h00;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rdata <= cfg_rd ? rd_mux : 8'h00;
            cfg_rvalid <= cfg_rd;
        end
    end
endmodule : odtt_ctrl

// *** odtt_bmc_model.sv ***
/* board controller model: counts cycles with the alert pin low.
   assumes the pin is always driven by the device, on clk. */
`timescale 1ns/1ps
module odtt_bmc_model (
    // clock
    input wire logic clk,
    // alert pin and what was seen
    input wire logic alert_n,
    output int low_cycles
);
    initial low_cycles = 0;
    always @(posedge clk) begin
        if (alert_n === 1'b0) begin
            low_cycles <= low_cycles + 1;
        end
    end
endmodule : odtt_bmc_model

// *** odtt_ctrl_props.sv ***
/* port assertions of the thermal throttle register bank.
   assumes one clock domain with synchronous active-high reset. */
`timescale 1ns/1ps
module odtt_ctrl_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // watched ports
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire odtt_pkg::odtt_byte_t cfg_rdata,
    input wire logic cfg_rvalid,
    input wire odtt_pkg::odtt_temp_t live_sensor_reading,
    input wire odtt_pkg::odtt_temp_t high_threshold,
    input wire odtt_pkg::odtt_temp_t standalone_throttle_threshold,
    input wire logic catastrophic_trip,
    input wire logic throttle_active,
    input wire logic throttle_hint,
    input wire logic thermal_alert_pin_n
);
    import odtt_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire st = cfg_rd && cfg_addr == 8'hf4;
    wire mapped = st || cfg_addr == 8'hf6 || cfg_addr == 8'hf7;
    wire below = $signed(live_sensor_reading) < $signed(high_threshold)
        && $signed(live_sensor_reading)
        < $signed(standalone_throttle_threshold);
    a_read_answer: assert property (cfg_rd |=> cfg_rvalid)
        else $error("read got no answer");
    a_idle_quiet: assert property (!cfg_rd |=> !cfg_rvalid && !cfg_rdata)
        else $error("read data without read");
    a_unmapped_zero: assert property (cfg_rd && !mapped |=> cfg_rdata == 0)
        else $error("unmapped read not zero");
    a_status_rsv: assert property (st |=> cfg_rdata[7:3] == 5'h0)
        else $error("status reserved bits set");
    a_cool_rsv: assert property (cfg_rd && cfg_addr == 8'hf6
        |=> cfg_rdata[7:1] == 7'h00) else $error("cooling reserved set");
    a_below_idle: assert property (below |=> !throttle_active)
        else $error("throttling below both thresholds");
    a_hint_gate: assert property (throttle_hint
        |-> throttle_active || $past(throttle_active))
        else $error("hint without throttling");
    a_trip_flag: assert property (catastrophic_trip[*4] ##0 st
        |=> cfg_rdata[0]) else $error("trip flag missing");
    a_alert_hold: assert property ($fell(thermal_alert_pin_n)
        |=> !thermal_alert_pin_n[*8]) else $error("alert too short");
    c_hint: cover property (throttle_active && throttle_hint);
    c_alert: cover property ($fell(thermal_alert_pin_n));
    c_unmapped: cover property (cfg_rd && !mapped);
endmodule : odtt_ctrl_props
bind odtt_ctrl odtt_ctrl_props u_props (.clk(clk), .reset(reset),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .live_sensor_reading(live_sensor_reading),
    .high_threshold(high_threshold),
    .standalone_throttle_threshold(standalone_throttle_threshold),
    .catastrophic_trip(catastrophic_trip),
    .throttle_active(throttle_active), .throttle_hint(throttle_hint),
    .thermal_alert_pin_n(thermal_alert_pin_n));

// *** tb_odtt_ctrl.sv ***
/* self-checking bench of the thermal throttle register bank.
   assumes design, package, checker and board model are compiled. */
`timescale 1ns/1ps
module tb_odtt_ctrl;
    import odtt_pkg::*;
    logic clk = 0, reset = 1, cfg_wr = 0, cfg_rd = 0, trip = 0, nm;
    logic [7:0] cfg_addr = 8'h00;
    odtt_byte_t cfg_wdata = 8'h00, cfg_rdata;
    odtt_temp_t sens = 9'h000, hi = 9'h0c8, lo = 9'h0b4, sa = 9'h0f0, peak;
    logic rvalid, thr, hint, alert_n;
    int failures = 0, comparisons = 0, low_cycles, lc;
    logic [31:0] seed = 32'h1629;
    always #4 clk = ~clk;
    odtt_ctrl uut (.clk(clk), .reset(reset), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(rvalid),
        .live_sensor_reading(sens), .high_threshold(hi),
        .low_threshold(lo), .standalone_throttle_threshold(sa),
        .catastrophic_trip(trip), .peak_temperature(peak),
        .throttle_active(thr), .throttle_hint(hint),
        .thermal_alert_pin_n(alert_n));
    odtt_bmc_model bmc (.clk(clk), .alert_n(alert_n),
        .low_cycles(low_cycles));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic exp_thr(input logic m, input odtt_temp_t s);
        return m ? $signed(s) >= $signed(sa) : $signed(s) >= $signed(hi);
    endfunction : exp_thr
    task automatic chk_temp(input odtt_temp_t got, input odtt_temp_t exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_temp
    task automatic chk_reg(input odtt_byte_t got, input odtt_byte_t exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
        @(negedge clk);
        cfg_wr = 0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge clk);
        cfg_rd = 0;
        chk_bit(rvalid, 1'b1);
        chk_reg(cfg_rdata, e);
    endtask : rdc
    task automatic drive(input odtt_temp_t s, input int n);
        @(negedge clk);
        sens = s;
        repeat (n) @(negedge clk);
    endtask : drive
    task automatic stop_test;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    // ----------------------------------------------------------------
    // main sequence; watchdog allows about fifteen times the run
    // ----------------------------------------------------------------
    initial begin
        #200000;
        failures++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge clk);
        reset = 0;
        rdc(8'hf4, 8'h04);
        rdc(8'hf6, 8'h00);
        rdc(8'hf7, 8'h00);
        wr(8'hf5, 8'hff);
        rdc(8'hf5, 8'h00);
        wr(8'hf7, 8'hf1);
        rdc(8'hf7, 8'h01);
        wr(8'hf6, 8'hff);
        rdc(8'hf6, 8'h01);
        drive(9'h0d0, 2);
        chk_bit(thr, 1'b0);
        chk_temp(peak, 9'h0d0);
        wr(8'hf4, 8'hff);
        rdc(8'hf4, 8'h00);
        wr(8'hf6, 8'h00);
        drive(9'h0d0, 2);
        chk_bit(thr, 1'b1);
        chk_bit(hint, 1'b0);
        rdc(8'hf4, 8'h02);
        wr(8'hf4, 8'h02);
        rdc(8'hf4, 8'h00);
        wr(8'hf7, 8'h02);
        drive(9'h0e0, 2);
        chk_bit(hint, 1'b1);
        chk_temp(peak, 9'h0e0);
        rdc(8'hf4, 8'h04);
        wr(8'hf7, 8'h03);
        drive(9'h0e0, 1);
        chk_temp(peak, 9'h100);
        wr(8'hf7, 8'h0a);
        drive(9'h0e0, 2);
        chk_temp(peak, 9'h0e0);
        chk_bit(thr, 1'b0);
        wr(8'hf4, 8'h07);
        drive(9'h0f0, 2);
        chk_bit(thr, 1'b1);
        rdc(8'hf4, 8'h06);
        wr(8'hf7, 8'h06);
        drive(9'h0f0, 300);
        chk_bit(low_cycles != 0, 1'b1);
        wr(8'hf7, 8'h0c);
        drive(9'h0c0, 300);
        lc = low_cycles;
        drive(9'h0c0, 300);
        chk_bit(low_cycles == lc, 1'b1);
        drive(9'h1f0, 300);
        chk_bit(low_cycles > lc, 1'b1);
        wr(8'hf4, 8'h07);
        trip = 1;
        repeat (4) @(negedge clk);
        rdc(8'hf4, 8'h01);
        // clear while the trip still stands: the set must win
        wr(8'hf4, 8'h01);
        rdc(8'hf4, 8'h01);
        trip = 0;
        // let the two synchroniser stages drain before clearing
        repeat (3) @(negedge clk);
        wr(8'hf4, 8'h01);
        repeat (4) @(negedge clk);
        rdc(8'hf4, 8'h00);
        for (int i = 0; i < 60; i++) begin
            seed = xs(seed);
            nm = seed[27];
            wr(8'hf7, {4'h0, nm, 3'b010});
            {hi, sa} = seed[17:0];
            drive(i == 0 ? hi : seed[26:18], 2);
            chk_bit(thr, exp_thr(nm, sens));
        end
        stop_test();
    end
endmodule : tb_odtt_ctrl
